// ==== rtl/uart_brg_pkg.sv ====
package uart_brg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Channels: each direction has its own divisor and rate generator; both share one prescaler select
    localparam int NUM_CH = 2;
    localparam int CH_TX  = 0;
    localparam int CH_RX  = 1;

    ////////////////////////////////////////////////////////////////////////////
    // APB register map (byte addresses, one aligned word each)
    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  CH_STRIDE         = 8'h10;
    localparam logic [7:0]  OFF_DIV_LOW       = 8'h00;
    localparam logic [7:0]  OFF_DIV_HIGH      = 8'h04;
    localparam logic [7:0]  OFF_DIV_FRAC      = 8'h08;
    localparam logic [7:0]  OFF_MODEM_CONTROL = 8'h20;
    localparam logic [7:0]  OFF_FIFO_CONTROL  = 8'h24;
    localparam logic [7:0]  OFF_LINE_STATE    = 8'h28;
    localparam logic [7:0]  OFF_INT_STATUS    = 8'h2C;
    localparam logic [7:0]  OFF_INT_CLEAR     = 8'h30;
    localparam logic [7:0]  OFF_INT_ENABLE    = 8'h34;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values: divisor of exactly one
    localparam logic [7:0]  DIV_LOW_RESET     = 8'h01;
    localparam logic [7:0]  DIV_HIGH_RESET    = 8'h00;
    localparam logic [5:0]  DIV_FRAC_RESET    = 6'h00;
    localparam logic [7:0]  MODEM_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  FIFO_CTRL_RESET   = 8'h00;
    localparam logic [2:0]  INT_ENABLE_RESET  = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PRESCALE_BIT = 7;
    localparam int FIFO_EN_BIT  = 0;
    localparam int FRAC_LSB     = 0;
    localparam int FRAC_W       = 4;
    localparam int MODE_LSB     = 4;
    localparam int NUM_EVENTS   = 3;
    localparam int EV_TX_BIT    = 0;
    localparam int EV_RX_BIT    = 1;
    localparam int EV_INT_RISE  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Sampling modes and cycle counts
    typedef enum logic [1:0] {
        MODE_16X  = 2'b00,
        MODE_8X   = 2'b01,
        MODE_4X   = 2'b10,
        MODE_RSVD = 2'b11
    } sample_mode_type;

    localparam logic [3:0] LAST_16X  = 4'hF;
    localparam logic [3:0] LAST_8X   = 4'h7;
    localparam logic [3:0] LAST_4X   = 4'h3;
    localparam logic [1:0] PRE_LAST  = 2'h3;

endpackage

// ==== rtl/rate_generator.sv ====
`timescale 1ns/100ps
module rate_generator
    import uart_brg_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               osc_tick,
    input  wire logic               prescale4,
    input  wire logic [15:0]        div_int,
    input  wire logic [FRAC_W-1:0]  div_frac,
    input  wire sample_mode_type    sample_mode,
    output logic                    sample_tick,
    output logic                    bit_tick
);

    logic [1:0]         pre_cnt;
    logic               pre_tick;
    logic [16:0]        div_eff;
    logic [FRAC_W-1:0]  acc;
    logic [FRAC_W:0]    acc_sum;
    logic [16:0]        period_last;
    logic [16:0]        per_cnt;
    logic [3:0]         bit_cnt;
    logic [3:0]         bit_last;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler divide select
    assign pre_tick = osc_tick && (!prescale4 || pre_cnt == PRE_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 2'h0;
        end else if (osc_tick) begin
            pre_cnt <= prescale4 ? pre_cnt + 2'h1 : 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // integer divisor of at least one
    assign div_eff = (div_int == 16'h0000) ? 17'h00001 : {1'b0, div_int};

    // carry of the fraction stretches a period
    assign acc_sum     = {1'b0, acc} + {1'b0, div_frac};
    assign period_last = div_eff - 17'h00001 + {16'h0000, acc_sum[FRAC_W]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt     <= 17'h00000;
            acc         <= '0;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= pre_tick && (per_cnt >= period_last);
            if (pre_tick) begin
                if (per_cnt >= period_last) begin
                    per_cnt <= 17'h00000;
                    acc     <= acc_sum[FRAC_W-1:0];
                end else begin
                    per_cnt <= per_cnt + 17'h00001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // samples per bit
    always_comb begin
        case (sample_mode)
            MODE_8X: bit_last = LAST_8X;
            MODE_4X: bit_last = LAST_4X;
            default: bit_last = LAST_16X;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt  <= 4'h0;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= sample_tick && (bit_cnt >= bit_last);
            if (sample_tick) begin
                bit_cnt <= (bit_cnt >= bit_last) ? 4'h0 : bit_cnt + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers: prescaled ticks per period, config change marker
    logic [16:0]            h_len;
    logic [15+FRAC_W:0]     h_cfg;
    logic                   h_dirty;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_len   <= 17'h00000;
            h_cfg   <= '0;
            h_dirty <= 1'b1;
        end else begin
            h_cfg <= {div_int, div_frac};
            if (sample_tick) begin
                h_len <= pre_tick ? 17'h00001 : 17'h00000;
            end else if (pre_tick) begin
                h_len <= h_len + 17'h00001;
            end
            if (h_cfg != {div_int, div_frac}) begin
                h_dirty <= 1'b1;
            end else if (sample_tick) begin
                h_dirty <= 1'b0;
            end
        end
    end

    a_period_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sample_tick && !h_dirty && h_cfg == {div_int, div_frac})
        |-> (h_len == div_eff || h_len == div_eff + 17'h00001))
        else $error("sampling period outside divisor bounds");

    a_prescale_tick: assert property (
        @(posedge pclk) disable iff (!presetn)
        (osc_tick && prescale4 && pre_cnt != PRE_LAST) |=> !sample_tick)
        else $error("sample tick without fourth oscillator edge");

    a_bit_rate_8x: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sample_tick && sample_mode == MODE_8X && bit_cnt == 4'h7) |=> bit_tick)
        else $error("8X bit tick missing after eighth sample");

    a_bit_rate_16x: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sample_tick && bit_cnt < 4'hF && sample_mode inside {MODE_16X, MODE_RSVD})
        |=> !bit_tick)
        else $error("16X bit tick before sixteenth sample");

endmodule

// ==== rtl/uart_brg_top.sv ====
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps

module uart_brg_top
    import uart_brg_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               osc_input_pin,
    input  wire logic               tx_above_trigger,
    input  wire logic               rx_above_trigger,
    input  wire logic               rx_timeout,
    output logic                    int_pin,
    output logic                    irq,
    output logic                    tx_sample_tick,
    output logic                    tx_bit_tick,
    output logic                    rx_sample_tick,
    output logic                    rx_bit_tick
);

    logic                   osc_meta;
    logic                   osc_sync;
    logic                   osc_prev;
    logic                   osc_tick;

    logic [7:0]             div_low     [NUM_CH];
    logic [7:0]             div_high    [NUM_CH];
    logic [5:0]             div_frac    [NUM_CH];
    logic [NUM_CH-1:0]      sample_tick;
    logic [NUM_CH-1:0]      bit_tick;

    logic [7:0]             modem_control_reg;
    logic [7:0]             fifo_control_reg;
    logic                   fifo_en;
    logic                   prescale4;

    logic [NUM_EVENTS-1:0]  int_status;
    logic [NUM_EVENTS-1:0]  int_enable;
    logic [NUM_EVENTS-1:0]  int_clear;
    logic [NUM_EVENTS-1:0]  events;
    logic [NUM_EVENTS-1:0]  next_int_status;
    logic                   int_pin_prev;
    logic                   next_int_pin;

    logic                   setup_phase;
    logic                   wr_en;
    logic [31:0]            rd_data;
    logic                   rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator pin: two stages, then rising edge detect on the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= osc_input_pin;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign osc_tick = osc_sync && !osc_prev;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait-free access phase.
    // The bus handshake never waits on the oscillator, so a stopped clock source
    // cannot hang software.
    assign setup_phase = psel && !penable;
    assign wr_en       = psel && penable && pwrite && pready;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (paddr)
            OFF_DIV_LOW:                    rd_data[7:0] = div_low[CH_TX];
            OFF_DIV_HIGH:                   rd_data[7:0] = div_high[CH_TX];
            OFF_DIV_FRAC:                   rd_data[5:0] = div_frac[CH_TX];
            CH_STRIDE + OFF_DIV_LOW:        rd_data[7:0] = div_low[CH_RX];
            CH_STRIDE + OFF_DIV_HIGH:       rd_data[7:0] = div_high[CH_RX];
            CH_STRIDE + OFF_DIV_FRAC:       rd_data[5:0] = div_frac[CH_RX];
            OFF_MODEM_CONTROL:              rd_data[7:0] = modem_control_reg;
            OFF_FIFO_CONTROL:               rd_data[7:0] = fifo_control_reg;
            OFF_LINE_STATE:                 rd_data[4:0] = {rx_timeout, rx_above_trigger,
                                                            tx_above_trigger, osc_sync,
                                                            int_pin};
            OFF_INT_STATUS:                 rd_data[NUM_EVENTS-1:0] = int_status;
            OFF_INT_CLEAR:                  rd_data = 32'h0000_0000;
            OFF_INT_ENABLE:                 rd_data[NUM_EVENTS-1:0] = int_enable;
            default:                        rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !rd_hit;
            if (setup_phase && !pwrite) begin
                prdata <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_control_reg <= MODEM_CTRL_RESET;
            fifo_control_reg  <= FIFO_CTRL_RESET;
        end else if (wr_en) begin
            if (paddr == OFF_MODEM_CONTROL) begin
                modem_control_reg <= pwdata[7:0];
            end
            if (paddr == OFF_FIFO_CONTROL) begin
                fifo_control_reg <= pwdata[7:0];
            end
        end
    end

    assign prescale4 = modem_control_reg[PRESCALE_BIT];
    assign fifo_en   = fifo_control_reg[FIFO_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Per-direction divisor registers and generators
    // independent divisor sets
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        localparam logic [7:0] BASE = CH_STRIDE * 8'(ch);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                div_low[ch]  <= DIV_LOW_RESET;
                div_high[ch] <= DIV_HIGH_RESET;
                div_frac[ch] <= DIV_FRAC_RESET;
            end else if (wr_en) begin
                if (paddr == BASE + OFF_DIV_LOW) begin
                    div_low[ch] <= pwdata[7:0];
                end
                if (paddr == BASE + OFF_DIV_HIGH) begin
                    div_high[ch] <= pwdata[7:0];
                end
                if (paddr == BASE + OFF_DIV_FRAC) begin
                    div_frac[ch] <= pwdata[5:0];
                end
            end
        end

        rate_generator u_rate_generator (
            .pclk        (pclk),
            .presetn     (presetn),
            .osc_tick    (osc_tick),
            .prescale4   (prescale4),
            .div_int     ({div_high[ch], div_low[ch]}),
            .div_frac    (div_frac[ch][FRAC_LSB +: FRAC_W]),
            .sample_mode (sample_mode_type'(div_frac[ch][MODE_LSB +: 2])),
            .sample_tick (sample_tick[ch]),
            .bit_tick    (bit_tick[ch])
        );
    end

    assign tx_sample_tick = sample_tick[CH_TX];
    assign tx_bit_tick    = bit_tick[CH_TX];
    assign rx_sample_tick = sample_tick[CH_RX];
    assign rx_bit_tick    = bit_tick[CH_RX];

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin from FIFO trigger state.
    // The two directions share the pin; a receive request forces it high even
    // while the transmit FIFO is above trigger, so receive data is never starved.
    // transmit trigger level
    assign next_int_pin = fifo_en && (!tx_above_trigger || rx_above_trigger || rx_timeout);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_pin      <= 1'b0;
            int_pin_prev <= 1'b0;
        end else begin
            int_pin      <= next_int_pin;
            int_pin_prev <= int_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event status, write-one-to-clear; a new event beats its clear
    assign events[EV_TX_BIT]   = bit_tick[CH_TX];
    assign events[EV_RX_BIT]   = bit_tick[CH_RX];
    assign events[EV_INT_RISE] = int_pin && !int_pin_prev;

    assign int_clear       = (wr_en && paddr == OFF_INT_CLEAR) ?
                             pwdata[NUM_EVENTS-1:0] : '0;
    assign next_int_status = (int_status & ~int_clear) | events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
        end else begin
            int_status <= next_int_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_enable <= INT_ENABLE_RESET;
        end else if (wr_en && paddr == OFF_INT_ENABLE) begin
            int_enable <= pwdata[NUM_EVENTS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_int_tx_above: assert property (
        @(posedge pclk) disable iff (!presetn)
        (fifo_en && tx_above_trigger && !rx_above_trigger && !rx_timeout) |=> !int_pin)
        else $error("interrupt pin not low with transmit FIFO above trigger");

    a_int_rx_above: assert property (
        @(posedge pclk) disable iff (!presetn)
        (fifo_en && (rx_above_trigger || rx_timeout)) |=> int_pin)
        else $error("interrupt pin not high on receive trigger or timeout");

    a_int_fifo_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !fifo_en |=> !int_pin)
        else $error("interrupt pin driven with FIFOs disabled");

    a_apb_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> (pready ##1 !pready))
        else $error("APB access phase not answered in one cycle");

    a_reset_divisor: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn)
        |-> (div_low[CH_TX] == DIV_LOW_RESET && div_low[CH_RX] == DIV_LOW_RESET
             && div_high[CH_TX] == DIV_HIGH_RESET && div_high[CH_RX] == DIV_HIGH_RESET
             && div_frac[CH_TX] == DIV_FRAC_RESET && div_frac[CH_RX] == DIV_FRAC_RESET))
        else $error("divisor not one after reset");

    a_int_tx_below: assert property (
        @(posedge pclk) disable iff (!presetn)
        (fifo_en && !tx_above_trigger) |=> int_pin)
        else $error("interrupt pin not high with transmit FIFO below trigger");

    // A bit event must survive a clear written in the same cycle
    a_status_set_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        (|events) |=> ((int_status & $past(events)) == $past(events)))
        else $error("status event lost to a same-cycle clear");

    a_apb_error: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !rd_hit) |=> (pready && pslverr))
        else $error("unmapped access not flagged");

    a_apb_no_error: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && rd_hit) |=> !pslverr)
        else $error("mapped access flagged as error");

    a_unmapped_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && !rd_hit) |=> ($stable(modem_control_reg) && $stable(fifo_control_reg)))
        else $error("unmapped write changed a control register");

    a_tx_low_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFF_DIV_LOW)
        |=> ({24'h00_0000, div_low[CH_TX]} == ($past(pwdata) & 32'h0000_00FF)))
        else $error("divisor low byte not written");

    a_tx_high_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFF_DIV_HIGH)
        |=> ({24'h00_0000, div_high[CH_TX]} == ($past(pwdata) & 32'h0000_00FF)))
        else $error("divisor high byte not written");

    a_tx_frac_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFF_DIV_FRAC)
        |=> ({26'h0, div_frac[CH_TX]} == ($past(pwdata) & 32'h0000_003F)))
        else $error("fraction register not written");

    a_rx_low_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CH_STRIDE + OFF_DIV_LOW)
        |=> ({24'h00_0000, div_low[CH_RX]} == ($past(pwdata) & 32'h0000_00FF)
             && $stable(div_low[CH_TX])))
        else $error("receive divisor write not independent");

    a_prescale_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFF_MODEM_CONTROL)
        |=> ({31'h0, prescale4} == (($past(pwdata) >> PRESCALE_BIT) & 32'h0000_0001)))
        else $error("prescale select not taken from modem control");

    a_fifo_enable: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFF_FIFO_CONTROL)
        |=> ({31'h0, fifo_en} == (($past(pwdata) >> FIFO_EN_BIT) & 32'h0000_0001)))
        else $error("FIFO enable not taken from FIFO control");

endmodule

// ==== tb/osc_source.sv ====
`timescale 1ns/100ps
// External clock source; it stands low while stopped
module osc_source (
    input  wire logic pclk,
    input  wire logic run,
    output logic      osc
);
    int cnt;
    initial begin
        osc = 1'b0;
        cnt = 0;
    end
    // Half period of 4 pclk keeps each level above the 2-cycle synchroniser minimum
    always @(posedge pclk) begin
        if (!run) begin
            osc <= 1'b0;
            cnt <= 0;
        end else if (cnt == 3) begin
            osc <= ~osc;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ==== tb/uart_fractional_baud_gen_tb.sv ====
`timescale 1ns/100ps
module uart_fractional_baud_gen_tb
    import uart_brg_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, osc, osc_run, err;
    logic        tx_above, rx_above, rx_to, pready, pslverr, int_pin, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  ticks;
    int          num_errors, total_checks, c;
    int          cyc = 0;

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    uart_brg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_input_pin(osc), .tx_above_trigger(tx_above),
        .rx_above_trigger(rx_above), .rx_timeout(rx_to), .int_pin(int_pin), .irq(irq),
        .tx_sample_tick(ticks[0]), .tx_bit_tick(ticks[1]), .rx_sample_tick(ticks[2]),
        .rx_bit_tick(ticks[3]));
    osc_source i_osc (.pclk(pclk), .run(osc_run), .osc(osc));

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Skips two ticks so a partial period after a change is not measured
    task automatic period(input int k, input int n, output int cnt);
        cnt = 0;
        for (int i = 0; i < n + 2; i++) begin
            if (i == 2)
                cnt = 0;
            do begin
                @(posedge pclk);
                cnt++;
            end while (ticks[k] !== 1'b1 && cnt < 30000);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] off [3] = '{OFF_DIV_LOW, OFF_DIV_HIGH, OFF_DIV_FRAC};
        logic [7:0] exp [3] = '{8'h01, 8'h00, 8'h00};
        for (int ch = 0; ch < 2; ch++) begin
            for (int r = 0; r < 3; r++) begin
                apb(1'b0, off[r] + (ch == 1 ? CH_STRIDE : 8'h00), 32'h0);
                chk("div_reset", {24'h0, exp[r]}, rd);
            end
        end
    endtask

    task automatic t_regs();
        apb(1'b1, OFF_DIV_HIGH, 32'h000001A5);
        apb(1'b0, OFF_DIV_HIGH, 32'h0);
        chk("div_high_no_osc", 32'h000000A5, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, 8'h40, 32'h0000_00FF);
        chk("unmapped_wr_err", 32'h1, {31'h0, err});
        apb(1'b1, OFF_DIV_HIGH, 32'h0);
    endtask

    task automatic t_rate();
        apb(1'b1, OFF_DIV_LOW, 32'h3);
        apb(1'b1, CH_STRIDE + OFF_DIV_LOW, 32'h2);
        apb(1'b1, CH_STRIDE + OFF_DIV_HIGH, 32'h1);
        osc_run <= 1'b1;
        period(0, 1, c);
        chk("tx_period", 32'd24, c);
        period(2, 1, c);
        chk("rx_period", 32'd2064, c);
        apb(1'b1, OFF_MODEM_CONTROL, 32'h80);
        period(0, 1, c);
        chk("tx_prescaled", 32'd96, c);
        apb(1'b1, OFF_MODEM_CONTROL, 32'h0);
    endtask

    task automatic t_modes();
        int exp [4] = '{128, 64, 32, 128};
        apb(1'b1, OFF_DIV_LOW, 32'h1);
        apb(1'b1, CH_STRIDE + OFF_DIV_LOW, 32'h1);
        apb(1'b1, CH_STRIDE + OFF_DIV_HIGH, 32'h0);
        apb(1'b1, CH_STRIDE + OFF_DIV_FRAC, 32'h10);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFF_DIV_FRAC, 32'(m << 4));
            period(1, 1, c);
            chk("bit_period", exp[m], c);
        end
        period(3, 1, c);
        chk("rx_bit_period", 32'd64, c);
    endtask

    task automatic t_frac();
        int fr [2] = '{5, 15};
        apb(1'b1, OFF_DIV_LOW, 32'h2);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFF_DIV_FRAC, 32'(fr[i]));
            period(0, 16, c);
            chk("frac_16_periods", (32 + fr[i]) * 8, c);
        end
        apb(1'b1, OFF_DIV_FRAC, 32'h15);
        period(1, 2, c);
        chk("bit_8x_odd_frac", 32'd296, c);
        apb(1'b1, OFF_DIV_FRAC, 32'h0);
        apb(1'b1, OFF_DIV_LOW, 32'h1);
    endtask

    task automatic t_int_pin();
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, OFF_FIFO_CONTROL, 32'(e));
            for (int v = 0; v < 8; v++) begin
                {rx_to, rx_above, tx_above} <= 3'(v);
                repeat (3) @(posedge pclk);
                c = 32'(e == 1 && (!v[0] || v[1] || v[2]));
                chk("int_pin", c, 32'(int_pin));
            end
        end
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk("status_int_rise", 32'h1, 32'(rd[2]));
    endtask

    task automatic t_irq();
        apb(1'b1, OFF_INT_CLEAR, 32'h7);
        apb(1'b1, OFF_INT_ENABLE, 32'h0);
        repeat (300) @(posedge pclk);
        chk("irq_masked", 32'h0, 32'(irq));
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk("status_tx_bit", 32'h1, 32'(rd[0]));
        chk("status_rx_bit", 32'h1, 32'(rd[1]));
        apb(1'b1, OFF_INT_ENABLE, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq_raised", 32'h1, 32'(irq));
        // Oscillator stopped first, else the event sets again at once
        osc_run <= 1'b0;
        repeat (300) @(posedge pclk);
        apb(1'b1, OFF_INT_CLEAR, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq_cleared", 32'h0, 32'(irq));
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk("status_cleared", 32'h0, 32'(rd[0]));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        osc_run = 1'b0;
        {tx_above, rx_above, rx_to} = 3'h0;
        num_errors = 0;
        total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regs();
        t_rate();
        t_modes();
        t_frac();
        t_int_pin();
        t_irq();
        end_of_test();
    end
endmodule
